// *** verilog/tap_chain_defines.vh ***
// Constants for the per-tile test access chain
`ifndef TAP_CHAIN_DEFINES_VH
`define TAP_CHAIN_DEFINES_VH
`define IR_WIDTH          4
`define IR_BYPASS         4'hf
`define IR_IDCODE         4'h1
`define IR_USERCODE       4'h2
`define IR_OTP_ACCESS     4'h3
`define IR_TILE_ACCESS    4'h4
`define IR_EXTEST         4'h0
`define IR_SAMPLE         4'h5
`define IR_CAPTURE        4'h1
`define SEC_JTAG_OFF_BIT  0
`define SEC_OTP_OFF_BIT   13
`define SEC_UID_HI        31
`define SEC_UID_LO        22
`define UC_UID_LO         22
`define UC_REV_WIDTH      16
`define TEST_RST_MIN_NS   100
`define CLK_PERIOD_NS     4
`define TEST_RST_CYCLES   ((`TEST_RST_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define S_RESET   4'h0
`define S_IDLE    4'h1
`define S_SEL_DR  4'h2
`define S_CAP_DR  4'h3
`define S_SH_DR   4'h4
`define S_EX1_DR  4'h5
`define S_PAU_DR  4'h6
`define S_EX2_DR  4'h7
`define S_UPD_DR  4'h8
`define S_SEL_IR  4'h9
`define S_CAP_IR  4'ha
`define S_SH_IR   4'hb
`define S_EX1_IR  4'hc
`define S_PAU_IR  4'hd
`define S_EX2_IR  4'he
`define S_UPD_IR  4'hf
`endif

// *** verilog/tap_port.v ***
// One test access port controller with instruction and data registers
`timescale 1ns/1ps
`include "tap_chain_defines.vh"
module tap_port #(
	parameter        DR_WIDTH = 32,
	parameter [31:0] ID_WORD  = 32'h0000_0001
) (
	input  wire                mclk_i,
	input  wire                rst_i,
	input  wire                held_i,
	input  wire                tck_rise_i,
	input  wire                tck_fall_i,
	input  wire                tms_i,
	input  wire                tdi_i,
	input  wire [31:0]         user_word_i,
	input  wire [DR_WIDTH-1:0] data_cap_i,
	output wire                tdo_o,
	output wire [`IR_WIDTH-1:0] ir_o,
	output wire [DR_WIDTH-1:0] data_upd_o,
	output wire                data_upd_stb_o
);
	reg [3:0]           state_reg;
	reg [3:0]           state_next;
	reg [`IR_WIDTH-1:0] ir_sh_reg;
	reg [`IR_WIDTH-1:0] ir_reg;
	reg [31:0]          dr_reg;
	reg [DR_WIDTH-1:0]  upd_reg;
	reg                 upd_stb_reg;
	reg                 tdo_reg;
	wire                dr_long;
	wire [31:0]         cap_ext;
	wire [31:0]         sh_ext;

	// Standard sixteen-state controller walk on tms
	always @* begin
		state_next = state_reg;
		case (state_reg)
			`S_RESET:  state_next = tms_i ? `S_RESET  : `S_IDLE;
			`S_IDLE:   state_next = tms_i ? `S_SEL_DR : `S_IDLE;
			`S_SEL_DR: state_next = tms_i ? `S_SEL_IR : `S_CAP_DR;
			`S_CAP_DR: state_next = tms_i ? `S_EX1_DR : `S_SH_DR;
			`S_SH_DR:  state_next = tms_i ? `S_EX1_DR : `S_SH_DR;
			`S_EX1_DR: state_next = tms_i ? `S_UPD_DR : `S_PAU_DR;
			`S_PAU_DR: state_next = tms_i ? `S_EX2_DR : `S_PAU_DR;
			`S_EX2_DR: state_next = tms_i ? `S_UPD_DR : `S_SH_DR;
			`S_UPD_DR: state_next = tms_i ? `S_SEL_DR : `S_IDLE;
			`S_SEL_IR: state_next = tms_i ? `S_RESET  : `S_CAP_IR;
			`S_CAP_IR: state_next = tms_i ? `S_EX1_IR : `S_SH_IR;
			`S_SH_IR:  state_next = tms_i ? `S_EX1_IR : `S_SH_IR;
			`S_EX1_IR: state_next = tms_i ? `S_UPD_IR : `S_PAU_IR;
			`S_PAU_IR: state_next = tms_i ? `S_EX2_IR : `S_PAU_IR;
			`S_EX2_IR: state_next = tms_i ? `S_UPD_IR : `S_SH_IR;
			`S_UPD_IR: state_next = tms_i ? `S_SEL_DR : `S_IDLE;
			default:   state_next = `S_RESET;
		endcase
	end

	// Bypass is one bit, all other instructions use the long register
	assign dr_long = (ir_reg != `IR_BYPASS);

	// Fit the data register width into the 32-bit shifter
	generate
		if (DR_WIDTH < 32) begin : g_short
			assign cap_ext = {{(32-DR_WIDTH){1'b0}}, data_cap_i};
			assign sh_ext  = {{(32-DR_WIDTH){1'b0}}, tdi_i, dr_reg[DR_WIDTH-1:1]};
		end else begin : g_full
			assign cap_ext = data_cap_i[31:0];
			assign sh_ext  = {tdi_i, dr_reg[31:1]};
		end
	endgenerate

	// Controller state and shift registers on tck rising edge
	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg   <= `S_RESET;
			ir_sh_reg   <= {`IR_WIDTH{1'b0}};
			ir_reg      <= `IR_IDCODE;
			dr_reg      <= 32'h0000_0000;
			upd_reg     <= {DR_WIDTH{1'b0}};
			upd_stb_reg <= 1'b0;
		end else if (held_i) begin
			state_reg   <= `S_RESET;
			ir_reg      <= `IR_IDCODE;
			upd_stb_reg <= 1'b0;
		end else begin
			upd_stb_reg <= 1'b0;
			if (tck_rise_i) begin
				state_reg <= state_next;
				case (state_reg)
					`S_RESET:  ir_reg <= `IR_IDCODE;
					`S_CAP_IR: ir_sh_reg <= `IR_CAPTURE;
					`S_SH_IR:  ir_sh_reg <= {tdi_i, ir_sh_reg[`IR_WIDTH-1:1]};
					`S_UPD_IR: ir_reg <= ir_sh_reg;
					`S_CAP_DR: begin
						if (ir_reg == `IR_IDCODE)
							dr_reg <= ID_WORD;
						else if (ir_reg == `IR_USERCODE)
							dr_reg <= user_word_i;
						else if (dr_long)
							dr_reg <= cap_ext;
						else
							dr_reg <= 32'h0000_0000;
					end
					`S_SH_DR: begin
						if (dr_long && ir_reg != `IR_IDCODE && ir_reg != `IR_USERCODE)
							dr_reg <= sh_ext;
						else if (dr_long)
							dr_reg <= {tdi_i, dr_reg[31:1]};
						else
							dr_reg <= {31'h0000_0000, tdi_i};
					end
					`S_UPD_DR: begin
						upd_reg     <= dr_reg[DR_WIDTH-1:0];
						upd_stb_reg <= 1'b1;
					end
					default: ;
				endcase
			end
		end
	end

	// Output changes on tck falling edge
	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i)
			tdo_reg <= 1'b0;
		else if (tck_fall_i)
			tdo_reg <= (state_reg == `S_SH_IR) ? ir_sh_reg[0] : dr_reg[0];
	end

	assign tdo_o          = tdo_reg;
	assign ir_o           = ir_reg;
	assign data_upd_o     = upd_reg;
	assign data_upd_stb_o = upd_stb_reg;
endmodule // tap_port

// *** verilog/tile_test_access.v ***
// Per-tile test access chain: boundary-scan port followed by chip port
`timescale 1ns/1ps
`include "tap_chain_defines.vh"
module tile_test_access #(
	parameter [3:0]  VERSION     = 4'h0,   // Arbitrary value
	parameter [15:0] PART_NUMBER = 16'h0001, // Arbitrary value
	parameter [10:0] MAKER_ID    = 11'h001, // Arbitrary value
	parameter [15:0] DIE_REV     = 16'h0001, // Arbitrary value
	parameter        PIN_COUNT   = 8
) (
	input  wire                 mclk_i,
	input  wire                 rst_i,
	input  wire                 rst_n_i,
	input  wire                 trst_n_i,
	input  wire                 tck_i,
	input  wire                 tms_i,
	input  wire                 tdi_i,
	output wire                 tdo_o,
	output wire                 tdo_oe_o,
	input  wire                 pll_lock_i,
	input  wire [31:0]          security_i,
	input  wire [PIN_COUNT-1:0] pin_state_i,
	output wire [PIN_COUNT-1:0] pin_drive_o,
	output wire                 pin_test_mode_o,
	output wire                 chip_reset_o,
	output wire                 boot_start_o,
	output wire                 otp_access_o,
	output wire                 tile_access_o,
	output wire [31:0]          chip_data_o,
	output wire                 chip_data_stb_o
);
	// Identification word layout, lowest bit fixed
	localparam [31:0] ID_WORD = {VERSION, PART_NUMBER, MAKER_ID, 1'b1};

	reg  [1:0]  trst_sync_reg;
	reg  [1:0]  tck_sync_reg;
	reg         tck_prev_reg;
	reg  [1:0]  tms_sync_reg;
	reg  [1:0]  tdi_sync_reg;
	reg  [1:0]  lock_sync_reg;
	reg  [1:0]  grst_sync_reg;
	reg         boot_reg;
	reg         jtag_off_reg;
	reg         otp_off_reg;
	reg  [9:0]  user_id_reg;
	reg         test_mode_reg;
	reg         otp_access_reg;
	reg         tile_access_reg;
	wire [PIN_COUNT-1:0] pin_sync;
	genvar      g;
	wire        held;
	wire        tck_rise;
	wire        tck_fall;
	wire        bs_tdo;
	wire        chip_tdo;
	wire [3:0]  bs_ir;
	wire [3:0]  chip_ir;
	wire [31:0] user_word;
	wire [PIN_COUNT-1:0] bs_upd;
	wire [31:0] chip_upd;
	wire        chip_upd_stb;

	// Global reset: asserts at once, releases through two flops
	always @(posedge mclk_i or posedge rst_i or negedge rst_n_i) begin
		if (rst_i || !rst_n_i)
			grst_sync_reg <= 2'b11;
		else
			grst_sync_reg <= {grst_sync_reg[0], 1'b0};
	end

	// Synchronise pins from outside the clock domain
	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			trst_sync_reg <= 2'b00;
			tck_sync_reg  <= 2'b00;
			tck_prev_reg  <= 1'b0;
			tms_sync_reg  <= 2'b11;
			tdi_sync_reg  <= 2'b00;
			lock_sync_reg <= 2'b00;
		end else begin
			trst_sync_reg <= {trst_sync_reg[0], trst_n_i};
			tck_sync_reg  <= {tck_sync_reg[0], tck_i};
			tck_prev_reg  <= tck_sync_reg[1];
			tms_sync_reg  <= {tms_sync_reg[0], tms_i};
			tdi_sync_reg  <= {tdi_sync_reg[0], tdi_i};
			lock_sync_reg <= {lock_sync_reg[0], pll_lock_i};
		end
	end

	// Security fields captured from the tile security register
	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			jtag_off_reg <= 1'b1;
			otp_off_reg  <= 1'b1;
			user_id_reg  <= 10'h000;
		end else begin
			jtag_off_reg <= security_i[`SEC_JTAG_OFF_BIT];
			otp_off_reg  <= security_i[`SEC_OTP_OFF_BIT];
			user_id_reg  <= security_i[`SEC_UID_HI:`SEC_UID_LO];
		end
	end

	// Boot waits for reset release and then for PLL lock
	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i)
			boot_reg <= 1'b0;
		else if (grst_sync_reg[1])
			boot_reg <= 1'b0;
		else if (lock_sync_reg[1])
			boot_reg <= 1'b1;
	end

	// Two-flop synchroniser per boundary pin before capture
	generate
		for (g = 0; g < PIN_COUNT; g = g + 1) begin : g_pin_sync
			reg meta_reg;
			reg sync_reg;
			always @(posedge mclk_i or posedge rst_i) begin
				if (rst_i) begin
					meta_reg <= 1'b0;
					sync_reg <= 1'b0;
				end else begin
					meta_reg <= pin_state_i[g];
					sync_reg <= meta_reg;
				end
			end
			assign pin_sync[g] = sync_reg;
		end
	endgenerate

	// Test reset low or disabled port keeps both controllers reset
	assign held     = !trst_sync_reg[1] || jtag_off_reg || grst_sync_reg[1];
	assign tck_rise = tck_sync_reg[1] && !tck_prev_reg;
	assign tck_fall = !tck_sync_reg[1] && tck_prev_reg;

	// User-code word: user field, zero gap, die revision
	assign user_word = {user_id_reg, {(`UC_UID_LO-`UC_REV_WIDTH){1'b0}}, DIE_REV};

	// Boundary-scan port, first in chain after the tester's data input
	tap_port #(.DR_WIDTH(PIN_COUNT), .ID_WORD(ID_WORD)) u_bs_port (
		.mclk_i         (mclk_i),
		.rst_i          (rst_i),
		.held_i         (held),
		.tck_rise_i     (tck_rise),
		.tck_fall_i     (tck_fall),
		.tms_i          (tms_sync_reg[1]),
		.tdi_i          (tdi_sync_reg[1]),
		.user_word_i    (user_word),
		.data_cap_i     (pin_sync),
		.tdo_o          (bs_tdo),
		.ir_o           (bs_ir),
		.data_upd_o     (bs_upd),
		.data_upd_stb_o ()
	);

	// Chip port, fed by the boundary-scan port output
	tap_port #(.DR_WIDTH(32), .ID_WORD(ID_WORD)) u_chip_port (
		.mclk_i         (mclk_i),
		.rst_i          (rst_i),
		.held_i         (held),
		.tck_rise_i     (tck_rise),
		.tck_fall_i     (tck_fall),
		.tms_i          (tms_sync_reg[1]),
		.tdi_i          (bs_tdo),
		.user_word_i    (user_word),
		.data_cap_i     (32'h0000_0000),
		.tdo_o          (chip_tdo),
		.ir_o           (chip_ir),
		.data_upd_o     (chip_upd),
		.data_upd_stb_o (chip_upd_stb)
	);

	// Access decodes registered so the outputs come from flops
	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			test_mode_reg   <= 1'b0;
			otp_access_reg  <= 1'b0;
			tile_access_reg <= 1'b0;
		end else begin
			test_mode_reg   <= !held && (bs_ir == `IR_EXTEST);
			otp_access_reg  <= !held && !otp_off_reg && (chip_ir == `IR_OTP_ACCESS);
			tile_access_reg <= !held && (chip_ir == `IR_TILE_ACCESS);
		end
	end

	// Chain output and its enable
	assign tdo_o           = chip_tdo;
	assign tdo_oe_o        = !held;

	// Boundary pin control
	assign pin_drive_o     = bs_upd;
	assign pin_test_mode_o = test_mode_reg;

	// Reset and boot status
	assign chip_reset_o    = grst_sync_reg[1];
	assign boot_start_o    = boot_reg;

	// OTP path refused while locked
	assign otp_access_o    = otp_access_reg;
	assign tile_access_o   = tile_access_reg;
	assign chip_data_o     = chip_upd;
	assign chip_data_stb_o = chip_upd_stb && (tile_access_o || otp_access_o);
endmodule // tile_test_access

// *** tb/tile_test_access_asserts.sv ***
// Assertion checker for the tile test access chain
`timescale 1ns/1ps
module tile_test_access_asserts (
	input wire		mclk_i,
	input wire		rst_i,
	input wire		rst_n_i,
	input wire		trst_n_i,
	input wire		tck_i,
	input wire		pll_lock_i,
	input wire [31:0]	security_i,
	input wire		tdo_o,
	input wire		tdo_oe_o,
	input wire		chip_reset_o,
	input wire		boot_start_o,
	input wire		otp_access_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	// Global reset release and the chip reset tail after it
	sequence s_release; $rose(rst_n_i); endsequence
	sequence s_tail; chip_reset_o [*2] ##[1:6] !chip_reset_o; endsequence
	// Reset, boot and test port guards
	a_reset_async: assert property (!rst_n_i [*2] |-> chip_reset_o)
		else $error("chip reset missing");
	a_reset_tail: assert property (s_release |-> s_tail)
		else $error("chip reset tail wrong");
	a_boot_held: assert property (chip_reset_o && $past(chip_reset_o) |-> !boot_start_o)
		else $error("boot during reset");
	a_boot_lock: assert property ($rose(boot_start_o) |-> $past(pll_lock_i, 2))
		else $error("boot without lock");
	a_trst_hold: assert property (!trst_n_i [*4] |-> !tdo_oe_o)
		else $error("port active in test reset");
	a_port_off: assert property (security_i[0] |-> !tdo_oe_o)
		else $error("port active while disabled");
	a_otp_block: assert property (security_i[13] |-> !otp_access_o)
		else $error("otp reached while blocked");
	a_tdo_stands: assert property (tck_i && $past(tck_i) |-> $stable(tdo_o))
		else $error("tdo moved while tck high");
endmodule // tile_test_access_asserts
bind tile_test_access tile_test_access_asserts u_chk (
	.mclk_i       (mclk_i),
	.rst_i        (rst_i),
	.rst_n_i      (rst_n_i),
	.trst_n_i     (trst_n_i),
	.tck_i        (tck_i),
	.pll_lock_i   (pll_lock_i),
	.security_i   (security_i),
	.tdo_o        (tdo_o),
	.tdo_oe_o     (tdo_oe_o),
	.chip_reset_o (chip_reset_o),
	.boot_start_o (boot_start_o),
	.otp_access_o (otp_access_o)
);

// *** tb/jtag_probe.sv ***
// Behavioural test controller for the serial test port
`timescale 1ns/1ps
module jtag_probe (
	input  wire	mclk_i,
	input  wire	tdo_i,
	output reg	tck_o = 1'b0,
	output reg	tms_o = 1'b1,
	output reg	tdi_o = 1'b0
);
	// One 80 ns test clock period, tdo taken on the rise
	task clk1(input ms, di, output so);
		tms_o <= ms;
		tdi_o <= di;
		repeat (10) @(posedge mclk_i);
		tck_o <= 1'b1;
		so = tdo_i;
		repeat (10) @(posedge mclk_i);
		tck_o <= 1'b0;
	endtask
	// Steer the state machine, first tms bit lowest
	task walk(input integer n, input [7:0] pat);
		integer j;
		reg d;
		for (j = 0; j < n; j = j + 1)
			clk1(pat[j], 1'b0, d);
	endtask
	// Shift n bits through IR or DR from idle, back to idle
	task scan(input ir, input integer n, input [63:0] din, output [63:0] dout);
		integer j;
		walk(ir ? 4 : 3, ir ? 8'h03 : 8'h01);
		for (j = 0; j < n; j = j + 1)
			clk1(j == n - 1, din[j], dout[j]);
		walk(2, 8'h01);
	endtask
endmodule // jtag_probe

// *** tb/tb_tile_test_access.sv ***
// Self-checking bench for the tile test access chain
`timescale 1ns/1ps
`include "tap_chain_defines.vh"
module tb_tile_test_access;
	// Identity of the default build
	localparam [31:0] ID	= {4'h0, 16'h0001, 11'h001, 1'b1};
	localparam [15:0] REV	= 16'h0001;
	reg		mclk_i = 1'b0, rst_i = 1'b1, rst_n_i = 1'b0, trst_n_i = 1'b0;
	reg		pll_lock_i = 1'b0;
	reg [31:0]	security_i = 32'h0, sec;
	reg [7:0]	pin_state_i = 8'h0;
	reg [63:0]	o, din;
	wire		tck_i, tms_i, tdi_i, tdo_o, tdo_oe_o, pin_test_mode_o, chip_reset_o;
	wire		boot_start_o, otp_access_o, tile_access_o, chip_data_stb_o;
	wire [7:0]	pin_drive_o;
	wire [31:0]	chip_data_o;
	integer		n_errors = 0, compares = 0, i, k, n_stb = 0, n0;
	// System clock
	always #2 mclk_i = ~mclk_i;
	// Count update strobes from the chip port
	always @(posedge mclk_i)
		if (chip_data_stb_o === 1'b1)
			n_stb <= n_stb + 1;
	tile_test_access dut (
		.mclk_i          (mclk_i),
		.rst_i           (rst_i),
		.rst_n_i         (rst_n_i),
		.trst_n_i        (trst_n_i),
		.tck_i           (tck_i),
		.tms_i           (tms_i),
		.tdi_i           (tdi_i),
		.tdo_o           (tdo_o),
		.tdo_oe_o        (tdo_oe_o),
		.pll_lock_i      (pll_lock_i),
		.security_i      (security_i),
		.pin_state_i     (pin_state_i),
		.pin_drive_o     (pin_drive_o),
		.pin_test_mode_o (pin_test_mode_o),
		.chip_reset_o    (chip_reset_o),
		.boot_start_o    (boot_start_o),
		.otp_access_o    (otp_access_o),
		.tile_access_o   (tile_access_o),
		.chip_data_o     (chip_data_o),
		.chip_data_stb_o (chip_data_stb_o)
	);
	jtag_probe p (.mclk_i(mclk_i), .tdo_i(tdo_o), .tck_o(tck_i), .tms_o(tms_i), .tdi_o(tdi_i));
	// Expected user-code word
	function [31:0] uc(input [31:0] s);
		uc = {s[31:22], 6'h0, REV};
	endfunction
	// Compare and count
	task chk(input [63:0] seen, exp, what);
		compares = compares + 1;
		if (seen !== exp) begin
			n_errors = n_errors + 1;
			$display("BAD %0s exp %0h seen %0h", what, exp, seen);
		end
	endtask
	// Counts and verdict
	task wrap_up;
		$display("compares %0d errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Both instruction registers, chip port in the low nibble
	task ir(input [7:0] v);
		p.scan(1'b1, 8, {56'h0, v}, o);
	endtask
	// System reset with a new security value
	task rst(input [31:0] s);
		rst_i <= 1'b1;
		security_i <= s;
		repeat (2) @(posedge mclk_i);
		rst_i <= 1'b0;
		repeat (8) @(posedge mclk_i);
		p.walk(6, 8'h1f);
	endtask
	// Lock the PLL and wait a bounded time for boot
	task boot;
		pll_lock_i <= 1'b1;
		for (i = 0; i < 40 && boot_start_o !== 1'b1; i = i + 1)
			@(negedge mclk_i);
		chk(boot_start_o, 1'b1, "boot");
		if (i == 40)
			wrap_up;
		@(posedge mclk_i);
	endtask
	// Hang guard
	initial begin
		#300000;
		n_errors = n_errors + 1;
		wrap_up;
	end
	// Main sequence
	initial begin
		k = $urandom(32'hf60ccb5e);
		repeat (2) @(posedge mclk_i);
		rst_i <= 1'b0;
		repeat (28) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		p.walk(6, 8'h1f);
		chk(tdo_oe_o, 1'b0, "oe_trst");
		chk(boot_start_o, 1'b0, "boot_nl");
		boot;
		trst_n_i <= 1'b1;
		repeat (8) @(posedge mclk_i);
		p.walk(6, 8'h1f);
		p.scan(1'b0, 64, 64'h0, o);
		chk(o[31:0], ID, "idcode");
		chk(o[32], 1'b1, "id2_lsb");
		for (k = 0; k < 6; k = k + 1) begin
			sec = (k == 0) ? 32'h0 : $urandom;
			sec[0] = 1'b0;
			sec[13] = k[0];
			din = {$urandom, $urandom};
			pin_state_i <= din[47:40];
			rst(sec);
			ir({`IR_BYPASS, `IR_USERCODE});
			chk(o[7:0], {2{`IR_CAPTURE}}, "ir_cap");
			p.scan(1'b0, 33, 64'h0, o);
			chk(o[31:0], uc(sec), "usercode");
			ir({`IR_BYPASS, `IR_OTP_ACCESS});
			chk(otp_access_o, !sec[13], "otp");
			ir({`IR_BYPASS, `IR_TILE_ACCESS});
			chk(tile_access_o, 1'b1, "tile");
			n0 = n_stb;
			p.scan(1'b0, 33, din, o);
			chk(chip_data_o, din[31:0], "chipdata");
			chk(n_stb - n0, 1, "stb");
			ir({`IR_EXTEST, `IR_BYPASS});
			chk(pin_test_mode_o, 1'b1, "extest");
			p.scan(1'b0, 9, {din[63:56], 1'b0}, o);
			chk({o[8:1], pin_drive_o}, {din[47:40], din[63:56]}, "pins");
		end
		rst(32'h1);
		ir({`IR_BYPASS, `IR_TILE_ACCESS});
		chk({tdo_oe_o, tile_access_o}, 2'b00, "jtag_off");
		rst_n_i <= 1'b0;
		#1 chk(chip_reset_o, 1'b1, "async");
		repeat (30) @(posedge mclk_i);
		chk(boot_start_o, 1'b0, "boot_rst");
		rst_n_i <= 1'b1;
		boot;
		wrap_up;
	end
endmodule // tb_tile_test_access
